/* hw/ieg_consts.vh */
// Offsets, field positions and reset values of the interrupt enable gating
`ifndef IEG_CONSTS_VH
`define IEG_CONSTS_VH
// Register offsets
`define IEG_MAIN_OFS      8'hA8
`define IEG_SEC_OFS       8'hA9
`define IEG_STAT_OFS      8'hAC
`define IEG_MASK_OFS      8'hAD
// Main enable register fields
`define IEG_GLOBAL_BIT    7
`define IEG_TMR2_BIT      5
`define IEG_UART_BIT      4
`define IEG_TMR1_BIT      3
`define IEG_EXT1_BIT      2
`define IEG_TMR0_BIT      1
`define IEG_EXT0_BIT      0
// Secondary enable register fields
`define IEG_PWM_BIT       7
`define IEG_CMP_BIT       6
`define IEG_PULSE_BIT     5
`define IEG_TWI_BIT       4
`define IEG_ADC_BIT       3
`define IEG_EXT2_BIT      2
`define IEG_PORT1_BIT     1
`define IEG_TMR3_BIT      0
// Reset values
`define IEG_MAIN_RST      8'h00
`define IEG_SEC_RST       8'h00
`define IEG_STAT_RST      8'h00
`define IEG_MASK_RST      8'h00
`endif

/* hw/ieg_gating.v */
// Interrupt enable gating with wake-up arming and a wake event status
//
// Behaviour
// - Global enable bit 7 blocks all IRQ_MAIN and IRQ_SEC requests when clear.
// - Main bit 5 gates the Timer2 request.
// - Main bit 4 gates the UART request.
// - Main bit 3 gates the Timer1 request.
// - Main bit 1 gates the Timer0 request.
// - Main bit 2 enables external pin 1 interrupt and Stop wake-up.
// - Main bit 0 enables external pin 0 interrupt and Stop wake-up.
// - Armed external pins wake from Stop regardless of the global enable.
// - Secondary bit 7 gates the shared PWM request.
// - Secondary bit 6 gates the combined comparator request.
// - Secondary bit 5 gates the pulse generator/detector request.
// - Secondary bit 4 gates the two-wire master request.
// - Secondary bit 3 gates the ADC request.
// - Secondary bit 2 enables external pin 2 interrupt and Stop wake-up.
// - Secondary bit 1 gates the Port1 pin-change request.
// - Secondary bit 0 gates the Timer3 request.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ieg_consts.vh"

module ieg_gating (
  // Clock and reset
  input  wire       CLK,
  input  wire       SYS_RST,
  // Register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Source flags
  input  wire       TMR0_FLAG,
  input  wire       TMR1_FLAG,
  input  wire       TMR2_FLAG,
  input  wire       TMR3_FLAG,
  input  wire       UART_FLAG,
  input  wire       PWM_FLAG,
  input  wire       CMP_FLAG,
  input  wire       PULSE_FLAG,
  input  wire       TWI_FLAG,
  input  wire       ADC_FLAG,
  input  wire       PORT1_FLAG,
  input  wire       EXT_PIN0,
  input  wire       EXT_PIN1,
  input  wire       EXT_PIN2,
  // Core side
  input  wire       STOP_MODE,
  output reg  [7:0] IRQ_MAIN,
  output reg  [7:0] IRQ_SEC,
  output reg        WAKE,
  output reg        IRQ
);

  // Enable, mask and status registers
  reg  [7:0] main_en_r;
  reg  [7:0] sec_en_r;
  reg  [7:0] stat_r;
  reg  [7:0] stat_nxt;
  reg  [7:0] mask_r;
  // Source flags, wake events and read data
  reg  [7:0] ev_main;
  reg  [7:0] ev_sec;
  reg  [2:0] wake_ev;
  reg  [7:0] rdata_nxt;
  wire       glb;
  // Strobe decodes
  reg        wr_main;
  reg        wr_sec;
  reg        wr_mask;
  reg        rd_stat;
  // Registered gated requests, one per source
  reg        req_tmr2_r;
  reg        req_uart_r;
  reg        req_tmr1_r;
  reg        req_ext1_r;
  reg        req_tmr0_r;
  reg        req_ext0_r;
  reg        req_pwm_r;
  reg        req_cmp_r;
  reg        req_pulse_r;
  reg        req_twi_r;
  reg        req_adc_r;
  reg        req_ext2_r;
  reg        req_port1_r;
  reg        req_tmr3_r;

  // Gate one request with its own enable and the global enable
  function gate;
    input flag;
    input own;
    input glob;
    begin
      gate = flag & own & glob;
    end
  endfunction

  // Match a strobe against one register address
  function sel;
    input [7:0] addr;
    input [7:0] ofs;
    input       strobe;
    begin
      sel = strobe & (addr == ofs);
    end
  endfunction

  // Register strobe decode, shared by the write and clear paths
  always @* begin
    wr_main = sel(ADDR, `IEG_MAIN_OFS, WR);
    wr_sec  = sel(ADDR, `IEG_SEC_OFS, WR);
    wr_mask = sel(ADDR, `IEG_MASK_OFS, WR);
    rd_stat = sel(ADDR, `IEG_STAT_OFS, RD);
  end

  assign glb = main_en_r[`IEG_GLOBAL_BIT];

  // Raw source flags laid out like the enable registers
  always @* begin
    ev_main = 8'h00;
    ev_main[`IEG_TMR2_BIT] = TMR2_FLAG;
    ev_main[`IEG_UART_BIT] = UART_FLAG;
    ev_main[`IEG_TMR1_BIT] = TMR1_FLAG;
    ev_main[`IEG_EXT1_BIT] = EXT_PIN1;
    ev_main[`IEG_TMR0_BIT] = TMR0_FLAG;
    ev_main[`IEG_EXT0_BIT] = EXT_PIN0;
    // Secondary register layout
    ev_sec = 8'h00;
    ev_sec[`IEG_PWM_BIT]   = PWM_FLAG;
    ev_sec[`IEG_CMP_BIT]   = CMP_FLAG;
    ev_sec[`IEG_PULSE_BIT] = PULSE_FLAG;
    ev_sec[`IEG_TWI_BIT]   = TWI_FLAG;
    ev_sec[`IEG_ADC_BIT]   = ADC_FLAG;
    ev_sec[`IEG_EXT2_BIT]  = EXT_PIN2;
    ev_sec[`IEG_PORT1_BIT] = PORT1_FLAG;
    ev_sec[`IEG_TMR3_BIT]  = TMR3_FLAG;
  end

  // wake ignores global enable; pins armed by their own bits
  always @* begin
    wake_ev[0] = STOP_MODE & EXT_PIN0 & main_en_r[`IEG_EXT0_BIT];
    wake_ev[1] = STOP_MODE & EXT_PIN1 & main_en_r[`IEG_EXT1_BIT];
    wake_ev[2] = STOP_MODE & EXT_PIN2 & sec_en_r[`IEG_EXT2_BIT];
  end

  // Wake status: a read clears it, a new event in that cycle wins
  always @* begin
    stat_nxt = stat_r;
    if (rd_stat)
      stat_nxt = 8'h00;
    stat_nxt = stat_nxt | {5'b0_0000, wake_ev};
  end

  // main enables reset to zero; bit 6 is not implemented
  always @(posedge CLK) begin
    if (SYS_RST)
      main_en_r <= `IEG_MAIN_RST;
    else if (wr_main)
      main_en_r <= {WDATA[7:6] & 2'b10, WDATA[5:0]}; // Bit 6 unused
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      sec_en_r <= `IEG_SEC_RST;
    else if (wr_sec)
      sec_en_r <= WDATA;
  end

  // Wake mask, only the three pin bits exist
  always @(posedge CLK) begin
    if (SYS_RST)
      mask_r <= `IEG_MASK_RST;
    else if (wr_mask)
      mask_r <= {5'b0_0000, WDATA[2:0]};
  end

  // Sticky wake status; events must not be lost to a clearing read
  always @(posedge CLK) begin
    if (SYS_RST)
      stat_r <= `IEG_STAT_RST;
    else
      stat_r <= stat_nxt;
  end

  // Read mux, zero for unmapped addresses and idle cycles
  always @* begin
    rdata_nxt = 8'h00;
    if (RD) begin
      case (ADDR)
        `IEG_MAIN_OFS: rdata_nxt = main_en_r;
        `IEG_SEC_OFS:  rdata_nxt = sec_en_r;
        `IEG_STAT_OFS: rdata_nxt = stat_r;
        `IEG_MASK_OFS: rdata_nxt = mask_r;
        default:       rdata_nxt = 8'h00;
      endcase
    end
  end

  // Read data register, valid only the cycle after the strobe
  always @(posedge CLK) begin
    if (SYS_RST)
      RDATA <= 8'h00;
    else
      RDATA <= rdata_nxt;
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_tmr2_r <= 1'b0;
    else
      req_tmr2_r <= gate(ev_main[`IEG_TMR2_BIT],
                         main_en_r[`IEG_TMR2_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_uart_r <= 1'b0;
    else
      req_uart_r <= gate(ev_main[`IEG_UART_BIT],
                         main_en_r[`IEG_UART_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_tmr1_r <= 1'b0;
    else
      req_tmr1_r <= gate(ev_main[`IEG_TMR1_BIT],
                         main_en_r[`IEG_TMR1_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_ext1_r <= 1'b0;
    else
      req_ext1_r <= gate(ev_main[`IEG_EXT1_BIT],
                         main_en_r[`IEG_EXT1_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_tmr0_r <= 1'b0;
    else
      req_tmr0_r <= gate(ev_main[`IEG_TMR0_BIT],
                         main_en_r[`IEG_TMR0_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_ext0_r <= 1'b0;
    else
      req_ext0_r <= gate(ev_main[`IEG_EXT0_BIT],
                         main_en_r[`IEG_EXT0_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_pwm_r <= 1'b0;
    else
      req_pwm_r <= gate(ev_sec[`IEG_PWM_BIT],
                        sec_en_r[`IEG_PWM_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_cmp_r <= 1'b0;
    else
      req_cmp_r <= gate(ev_sec[`IEG_CMP_BIT],
                        sec_en_r[`IEG_CMP_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_pulse_r <= 1'b0;
    else
      req_pulse_r <= gate(ev_sec[`IEG_PULSE_BIT],
                          sec_en_r[`IEG_PULSE_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_twi_r <= 1'b0;
    else
      req_twi_r <= gate(ev_sec[`IEG_TWI_BIT],
                        sec_en_r[`IEG_TWI_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_adc_r <= 1'b0;
    else
      req_adc_r <= gate(ev_sec[`IEG_ADC_BIT],
                        sec_en_r[`IEG_ADC_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_ext2_r <= 1'b0;
    else
      req_ext2_r <= gate(ev_sec[`IEG_EXT2_BIT],
                         sec_en_r[`IEG_EXT2_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_port1_r <= 1'b0;
    else
      req_port1_r <= gate(ev_sec[`IEG_PORT1_BIT],
                          sec_en_r[`IEG_PORT1_BIT], glb);
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      req_tmr3_r <= 1'b0;
    else
      req_tmr3_r <= gate(ev_sec[`IEG_TMR3_BIT],
                         sec_en_r[`IEG_TMR3_BIT], glb);
  end

  // Gated requests laid out like the enable registers, wiring only
  always @* begin
    // Bits 7 and 6 of the main layout stay zero
    IRQ_MAIN = 8'h00;
    IRQ_MAIN[`IEG_TMR2_BIT] = req_tmr2_r;
    IRQ_MAIN[`IEG_UART_BIT] = req_uart_r;
    IRQ_MAIN[`IEG_TMR1_BIT] = req_tmr1_r;
    IRQ_MAIN[`IEG_EXT1_BIT] = req_ext1_r;
    IRQ_MAIN[`IEG_TMR0_BIT] = req_tmr0_r;
    IRQ_MAIN[`IEG_EXT0_BIT] = req_ext0_r;
    IRQ_SEC = 8'h00;
    IRQ_SEC[`IEG_PWM_BIT]   = req_pwm_r;
    IRQ_SEC[`IEG_CMP_BIT]   = req_cmp_r;
    IRQ_SEC[`IEG_PULSE_BIT] = req_pulse_r;
    IRQ_SEC[`IEG_TWI_BIT]   = req_twi_r;
    IRQ_SEC[`IEG_ADC_BIT]   = req_adc_r;
    IRQ_SEC[`IEG_EXT2_BIT]  = req_ext2_r;
    IRQ_SEC[`IEG_PORT1_BIT] = req_port1_r;
    IRQ_SEC[`IEG_TMR3_BIT]  = req_tmr3_r;
  end

  // wake pulse, independent of global enable
  always @(posedge CLK) begin
    if (SYS_RST) begin
      WAKE <= 1'b0;
      IRQ  <= 1'b0;
    end else begin
      WAKE <= |wake_ev;
      // Next status, so a clearing read drops the line at once
      IRQ  <= |(stat_nxt & mask_r);
    end
  end

endmodule

`default_nettype wire

/* testbench/ieg_chk_sva.sv */
// Checker for the gated request, wake and read outputs
`timescale 1ns/1ps
`default_nettype none
module ieg_chk (
  // Watched ports
  input wire logic       CLK, SYS_RST, WR, RD, STOP_MODE, WAKE,
  input wire logic [7:0] ADDR, WDATA, RDATA, IRQ_MAIN, IRQ_SEC,
  input wire logic       TMR0_FLAG, TMR1_FLAG, TMR2_FLAG, TMR3_FLAG,
  input wire logic       UART_FLAG, PWM_FLAG, CMP_FLAG, PULSE_FLAG,
  input wire logic       TWI_FLAG, ADC_FLAG, PORT1_FLAG,
  input wire logic       EXT_PIN0, EXT_PIN1, EXT_PIN2
);
  logic [7:0] m_r, s_r, em_r, es_r;
  logic       ew_r;
  // Shadow enables and the expected outputs one cycle on
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {m_r, s_r, em_r, es_r, ew_r} <= '0;
    end else begin
      if (WR && ADDR == 8'hA8) m_r <= WDATA & 8'hBF;
      if (WR && ADDR == 8'hA9) s_r <= WDATA;
      em_r <= {2'b00, TMR2_FLAG, UART_FLAG, TMR1_FLAG, EXT_PIN1, TMR0_FLAG,
               EXT_PIN0} & m_r & {8{m_r[7]}};
      es_r <= {PWM_FLAG, CMP_FLAG, PULSE_FLAG, TWI_FLAG, ADC_FLAG, EXT_PIN2,
               PORT1_FLAG, TMR3_FLAG} & s_r & {8{m_r[7]}};
      ew_r <= STOP_MODE & |{EXT_PIN2 & s_r[2], EXT_PIN1 & m_r[2],
                            EXT_PIN0 & m_r[0]};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_glob; !m_r[7] |=> IRQ_MAIN == 8'h00 && IRQ_SEC == 8'h00;
  endproperty
  a_glob: assert property (p_glob) else $error("request passed");
  property p_main; IRQ_MAIN == em_r; endproperty
  a_main: assert property (p_main) else $error("main gating");
  property p_sec; IRQ_SEC == es_r; endproperty
  a_sec: assert property (p_sec) else $error("secondary gating");
  property p_wake; WAKE == ew_r; endproperty
  a_wake: assert property (p_wake) else $error("wake level");
  property p_wkg; STOP_MODE && EXT_PIN0 && m_r[0] && !m_r[7] |=> WAKE;
  endproperty
  a_wkg: assert property (p_wkg) else $error("wake blocked");
  property p_rdm; RD && ADDR == 8'hA8 |=> RDATA == $past(m_r); endproperty
  a_rdm: assert property (p_rdm) else $error("main readback");
  property p_rds; RD && ADDR == 8'hA9 |=> RDATA == $past(s_r); endproperty
  a_rds: assert property (p_rds) else $error("sec readback");
  property p_idle; !RD |=> RDATA == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stale read data");
  c_main: cover property (IRQ_MAIN != 8'h00);
  c_sec: cover property (IRQ_SEC != 8'h00);
  c_wake: cover property (WAKE && !m_r[7]);
endmodule
bind ieg_gating ieg_chk ieg_chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .WR(WR),
  .RD(RD), .STOP_MODE(STOP_MODE), .WAKE(WAKE), .ADDR(ADDR), .WDATA(WDATA),
  .RDATA(RDATA), .IRQ_MAIN(IRQ_MAIN), .IRQ_SEC(IRQ_SEC),
  .TMR0_FLAG(TMR0_FLAG), .TMR1_FLAG(TMR1_FLAG), .TMR2_FLAG(TMR2_FLAG),
  .TMR3_FLAG(TMR3_FLAG), .UART_FLAG(UART_FLAG), .PWM_FLAG(PWM_FLAG),
  .CMP_FLAG(CMP_FLAG), .PULSE_FLAG(PULSE_FLAG), .TWI_FLAG(TWI_FLAG),
  .ADC_FLAG(ADC_FLAG), .PORT1_FLAG(PORT1_FLAG), .EXT_PIN0(EXT_PIN0),
  .EXT_PIN1(EXT_PIN1), .EXT_PIN2(EXT_PIN2));
`default_nettype wire

/* testbench/ieg_core.sv */
// Core stand-in: enters Stop on request and leaves it on wake
`timescale 1ns/1ps
`default_nettype none
module ieg_core (
  // Clock, reset, sleep request, wake, Stop level
  input wire logic CLK, SYS_RST, sleep_req, wake,
  output var logic stop_r
);
  // Stop state, wake wins over a new request
  always_ff @(posedge CLK) begin
    if (SYS_RST || wake) stop_r <= 1'b0;
    else if (sleep_req) stop_r <= 1'b1;
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the enable gating block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK = 0, SYS_RST = 1, WR = 0, RD = 0, sleep = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, fs = 8'h00;
  logic [5:0] fm = 6'h00;
  wire logic [7:0] RDATA, IRQ_MAIN, IRQ_SEC;
  wire logic WAKE, IRQ, stop;
  int miscompares = 0, check_count = 0, cyc = 0;
  ieg_gating ieg_gating_i (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TMR0_FLAG(fm[1]),
    .TMR1_FLAG(fm[3]), .TMR2_FLAG(fm[5]), .TMR3_FLAG(fs[0]),
    .UART_FLAG(fm[4]), .PWM_FLAG(fs[7]), .CMP_FLAG(fs[6]),
    .PULSE_FLAG(fs[5]), .TWI_FLAG(fs[4]), .ADC_FLAG(fs[3]),
    .PORT1_FLAG(fs[1]), .EXT_PIN0(fm[0]), .EXT_PIN1(fm[2]),
    .EXT_PIN2(fs[2]), .STOP_MODE(stop), .IRQ_MAIN(IRQ_MAIN),
    .IRQ_SEC(IRQ_SEC), .WAKE(WAKE), .IRQ(IRQ));
  ieg_core ieg_core_i (.CLK(CLK), .SYS_RST(SYS_RST), .sleep_req(sleep),
    .wake(WAKE), .stop_r(stop));
  initial forever #25 CLK = ~CLK;
  // Hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      end_sim;
    end
  end
  task chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK) WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK) RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask
  task outs(input logic [7:0] m, s);
    repeat (2) @(posedge CLK);
    #1 chk(IRQ_MAIN, m);
    chk(IRQ_SEC, s);
  endtask
  // Reset values, bit 6 readback and an unmapped read
  task t_regs;
    rd(8'hA8, 8'h00);
    rd(8'hA9, 8'h00);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'hBF);
    rd(8'h00, 8'h00);
  endtask
  // Global enable off blocks all, then each enable alone
  task t_gate;
    fm <= 6'h3F;
    fs <= 8'hFF;
    wr(8'hA9, 8'hFF);
    wr(8'hA8, 8'h7F);
    outs(8'h00, 8'h00);
    wr(8'hA8, 8'hBF);
    outs(8'h3F, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(8'hA9, 8'h01 << i);
      outs(8'h3F, 8'h01 << i);
    end
    wr(8'hA9, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'hA8, 8'h80 | (8'h01 << i));
      outs((8'h01 << i) & 8'h3F, 8'h00);
    end
  endtask
  // Pin wake in Stop with global off, status read and interrupt
  task t_wake;
    fm <= 6'h00;
    fs <= 8'h04;
    wr(8'hA9, 8'h00);
    wr(8'hA8, 8'h01);
    wr(8'hAD, 8'h07);
    rd(8'hAD, 8'h07);
    @(posedge CLK) sleep <= 1'b1;
    @(posedge CLK) sleep <= 1'b0;
    repeat (4) @(posedge CLK);
    #1 chk({7'h00, stop}, 8'h01);
    fm <= 6'h01;
    repeat (3) @(posedge CLK);
    #1 chk({7'h00, stop}, 8'h00);
    chk({7'h00, IRQ}, 8'h01);
    chk(IRQ_MAIN, 8'h00);
    rd(8'hAC, 8'h01);
    repeat (2) @(posedge CLK);
    #1 chk({7'h00, IRQ}, 8'h00);
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_regs;
    t_gate;
    t_wake;
    end_sim;
  end
endmodule
`default_nettype wire
